// file: inc/mtc_pkg.sv
// package: register map, fields, reset values and timing for the trigger control block
package mtc_pkg;
  localparam int unsigned NUM_MEAS = 8;
  localparam int unsigned AW = 12;
  // register byte addresses
  localparam logic [11:0] OFF_CMD     = 12'h000;
  localparam logic [11:0] OFF_MODE    = 12'h004;
  localparam logic [11:0] OFF_ENABLE  = 12'h008;
  localparam logic [11:0] OFF_SCREEN  = 12'h00C;
  localparam logic [11:0] OFF_STATUS  = 12'h010;
  localparam logic [11:0] OFF_RESULT  = 12'h014;
  localparam logic [11:0] OFF_STORE   = 12'h018;
  localparam logic [11:0] OFF_MEASSEL = 12'h01C;
  // command register fields
  localparam int CMD_TRG     = 0;
  localparam int CMD_ABORT   = 1;
  localparam int CMD_RESET   = 2;
  localparam int CMD_LOCAL   = 3;
  localparam int CMD_REMOTE  = 4;
  localparam int CMD_SAVE    = 5;
  localparam int CMD_RECALL  = 6;
  localparam int CMD_NUM_LSB = 8;
  localparam int CMD_NUM_W   = 7;
  // mode register fields
  localparam int MODE_FAST   = 0;
  localparam int MODE_SINGLE = 1;
  localparam int MODE_AUTOR  = 2;
  localparam logic [2:0] MODE_RST = 3'h4;
  localparam logic [6:0] SLOT_MAX = 7'h63;
  // timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SETTLE_US     = 50;
  localparam int unsigned SETTLE_CYC    = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned AUTORANGE_US  = 20;
  localparam int unsigned AUTORANGE_CYC = AUTORANGE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W         = 16;
  localparam logic [31:0] ERR_WORD = 32'hDEAD_0000;
endpackage

// file: core/mtc_slot_mem.sv
// memory: per-measurement held results with registered read data
`timescale 1ns/100ps
`default_nettype none
module mtc_slot_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned DW    = 32
) (
  input  wire logic                     clk_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [DW-1:0]            wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [DW-1:0]            rdata_o
);
  logic [DW-1:0] mem [DEPTH];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// file: core/mtc_delay.sv
// settling and ranging delay timer, one pulse when the programmed wait has run
`timescale 1ns/100ps
`default_nettype none
module mtc_delay #(
  parameter int unsigned CW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic          cancel_i,
  input  wire logic [CW-1:0] len_i,
  output logic               done_o
);
  typedef struct packed {
    logic          run;
    logic [CW-1:0] cnt;
    logic          done;
  } mtc_dly_t;
  mtc_dly_t s_r, s_nxt;
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (cancel_i) begin
      s_nxt.run = 1'b0;
    end else if (start_i) begin
      if (len_i == '0) begin
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.run = 1'b1;
        s_nxt.cnt = len_i;
      end
    end else if (s_r.run) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.cnt == {{(CW-1){1'b0}}, 1'b1}) begin
        s_nxt.run  = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign done_o = s_r.done;
endmodule
`default_nettype wire

// file: core/mtc_trigger_ctrl.sv
// top: trigger, rearm_policy, settling and save/recall control with an APB slave
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - bus trigger pin, common trigger and immediate command act the same
// - a trigger while idle or measuring starts a cycle on every active measurement; one during settling is ignored
// - active means on the shown screen and switched on
// - one-shot: stop after valid result, hold results until next trigger; a fresh remote also clears the valid flags of active measurements
// - one-shot: repeated queries return the same held value
// - continuous: restart cycle right after each valid result
// - continuous: re-arm external measurements after each valid result
// - continuous: successive queries return fresh values
// - cycles without valid result retry until valid or aborted
// - full settling waits for external and internal transients
// - fast settling inserts no settling delay
// - autorange delay applies in both settling modes
// - read of an invalid result stalls the bus until valid
// - recall takes number 0 to 99 and restores that slot
// - save takes number 0 to 99 and stores into that slot
// - recall refuses numbers above 99
// - save refuses numbers above 99
// - power-on, preset, local or reset: full, continuous; fresh remote: last written mode, else full, continuous
// - abort stops cycles and readies for a new command
module mtc_trigger_ctrl #(
  parameter int unsigned NM = mtc_pkg::NUM_MEAS
) (
  input  wire logic          MCLK_I,
  input  wire logic          RESETN_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [11:0]   PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  input  wire logic          GET_I,
  input  wire logic [NM-1:0] MEAS_SCREEN_I,
  input  wire logic [NM-1:0] MEAS_DONE_I,
  input  wire logic [NM-1:0] MEAS_OK_I,
  input  wire logic [31:0]   MEAS_DATA_I,
  output logic      [NM-1:0] MEAS_START_O,
  output logic      [NM-1:0] MEAS_ARM_O,
  output logic      [NM-1:0] MEAS_ABORT_O,
  output logic               STORE_SAVE_O,
  output logic               STORE_RECALL_O,
  output logic      [6:0]    STORE_SLOT_O
);
  import mtc_pkg::*;
  localparam int unsigned MW = $clog2(NM);

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_MEAS} mtc_st_t;
  typedef struct packed {
    logic [1:0]    rst_sync;
    logic [2:0]    get_sync;
    logic          get_seen;
    logic [2:0]    mode;
    logic          remote;
    logic          remote_mode_set;
    logic [2:0]    remote_mode;
    logic [NM-1:0] enable;
    logic [NM-1:0] valid;
    logic [NM-1:0] busy;
    mtc_st_t       st;
    logic [NM-1:0] start;
    logic [NM-1:0] arm;
    logic [NM-1:0] abort;
    logic          dly_go;
    logic          save;
    logic          recall;
    logic [6:0]    slot;
    logic          slot_err;
    logic [MW-1:0] qsel;
    logic          rd_wait;
    logic          rd_stage;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
  } mtc_state_t;
  mtc_state_t s_r, s_nxt;

  logic          rst_n;
  logic          dly_done;
  logic [NM-1:0] active;
  logic [31:0]   mem_rdata;
  logic [CNT_W-1:0] dly_len;
  logic          trg_event;
  logic          setup_ph;
  logic          acc_ph;

  assign rst_n = s_r.rst_sync[1];

  function automatic logic [31:0] pad32(input logic [NM-1:0] v);
    pad32 = 32'h0000_0000 | 32'(v);
  endfunction

  // settling length follows mode; autorange wait applies in any mode
  always_comb begin
    dly_len = '0;
    if (!s_r.mode[MODE_FAST]) begin
      dly_len = CNT_W'(SETTLE_CYC);
    end
    if (s_r.mode[MODE_AUTOR]) begin
      dly_len = dly_len + CNT_W'(AUTORANGE_CYC);
    end
  end

  mtc_delay #(.CW(CNT_W)) u_dly (
    .clk_i    (MCLK_I),
    .rst_n_i  (rst_n),
    .start_i  (s_r.dly_go),
    .cancel_i (|s_r.abort),
    .len_i    (dly_len),
    .done_o   (dly_done)
  );

  mtc_slot_mem #(.DEPTH(NM), .DW(32)) u_mem (
    .clk_i   (MCLK_I),
    .we_i    (|(s_r.busy & MEAS_DONE_I & MEAS_OK_I)),
    .waddr_i (done_idx(s_r.busy & MEAS_DONE_I & MEAS_OK_I)),
    .wdata_i (MEAS_DATA_I),
    .raddr_i (s_r.qsel),
    .rdata_o (mem_rdata)
  );

  function automatic logic [MW-1:0] done_idx(input logic [NM-1:0] v);
    done_idx = '0;
    for (int i = NM - 1; i >= 0; i--) begin
      if (v[i]) begin
        done_idx = MW'(i);
      end
    end
  endfunction

  assign active    = MEAS_SCREEN_I & s_r.enable;
  assign setup_ph  = PSEL_I && !PENABLE_I;
  assign acc_ph    = PSEL_I && PENABLE_I;
  assign trg_event = s_r.get_sync[2] && s_r.get_sync[1] && !s_r.get_seen;

  always_comb begin
    logic [NM-1:0] fin;
    logic          cmd_trg;
    fin        = '0;
    cmd_trg    = 1'b0;
    s_nxt          = s_r;
    s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
    s_nxt.get_sync = {s_r.get_sync[1:0], GET_I};
    if (s_r.get_sync[2] == s_r.get_sync[1]) begin
      s_nxt.get_seen = s_r.get_sync[1];
    end
    s_nxt.start   = '0;
    s_nxt.arm     = '0;
    s_nxt.abort   = '0;
    s_nxt.dly_go  = 1'b0;
    s_nxt.save    = 1'b0;
    s_nxt.recall  = 1'b0;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    ////////////////////////////////////////////////////////////////////
    // apb slave
    if (setup_ph) begin
      s_nxt.rd_wait  = !PWRITE_I && PADDR_I == OFF_RESULT;
      s_nxt.rd_stage = 1'b0;
    end
    if (acc_ph && !s_r.pready) begin
      if (PWRITE_I) begin
        s_nxt.pready = 1'b1;
        case (PADDR_I)
          OFF_CMD: begin
            cmd_trg = PWDATA_I[CMD_TRG];
            if (PWDATA_I[CMD_ABORT]) begin
              s_nxt.abort = s_r.busy;
              s_nxt.busy  = '0;
              s_nxt.st    = ST_IDLE;
            end
            if (PWDATA_I[CMD_RESET] || PWDATA_I[CMD_LOCAL]) begin
              s_nxt.mode = MODE_RST;
              if (PWDATA_I[CMD_LOCAL]) begin
                s_nxt.remote = 1'b0;
              end
            end
            if (PWDATA_I[CMD_REMOTE] && !s_r.remote) begin
              s_nxt.remote = 1'b1;
              s_nxt.mode   = s_r.remote_mode_set ? s_r.remote_mode : MODE_RST;
              s_nxt.valid  = s_r.valid & ~active;
              if (!s_nxt.mode[MODE_SINGLE]) begin
                cmd_trg = 1'b1;
              end
            end
            if (PWDATA_I[CMD_SAVE] || PWDATA_I[CMD_RECALL]) begin
              if (PWDATA_I[CMD_NUM_LSB +: CMD_NUM_W] > SLOT_MAX) begin
                s_nxt.slot_err = 1'b1;
                s_nxt.pslverr  = 1'b1;
              end else begin
                s_nxt.slot_err = 1'b0;
                s_nxt.slot     = PWDATA_I[CMD_NUM_LSB +: CMD_NUM_W];
                s_nxt.save     = PWDATA_I[CMD_SAVE];
                s_nxt.recall   = PWDATA_I[CMD_RECALL];
              end
            end
          end
          OFF_MODE: begin
            s_nxt.mode            = PWDATA_I[2:0];
            s_nxt.remote_mode     = PWDATA_I[2:0];
            s_nxt.remote_mode_set = 1'b1;
          end
          OFF_ENABLE:  s_nxt.enable = PWDATA_I[NM-1:0];
          OFF_MEASSEL: s_nxt.qsel   = PWDATA_I[MW-1:0];
          default: s_nxt.pslverr = 1'b1;
        endcase
      end else begin
        case (PADDR_I)
          OFF_CMD:     s_nxt.prdata = '0;
          OFF_MODE:    s_nxt.prdata = {29'h0, s_r.mode};
          OFF_ENABLE:  s_nxt.prdata = pad32(s_r.enable);
          OFF_SCREEN:  s_nxt.prdata = pad32(MEAS_SCREEN_I);
          OFF_STATUS:  s_nxt.prdata = {16'(s_r.busy), 16'(s_r.valid)};
          OFF_STORE:   s_nxt.prdata = {24'h0, s_r.slot_err, s_r.slot};
          OFF_MEASSEL: s_nxt.prdata = 32'(s_r.qsel);
          default:     s_nxt.prdata = ERR_WORD;
        endcase
        if (PADDR_I == OFF_RESULT) begin
          // stall until the chosen result is valid, then one stage for memory
          if (s_r.valid[s_r.qsel]) begin
            s_nxt.rd_stage = 1'b1;
            if (s_r.rd_stage) begin
              s_nxt.prdata = mem_rdata;
              s_nxt.pready = 1'b1;
            end
          end
        end else begin
          s_nxt.pready  = 1'b1;
          s_nxt.pslverr = !(PADDR_I inside {OFF_CMD, OFF_MODE, OFF_ENABLE, OFF_SCREEN,
                                            OFF_STATUS, OFF_STORE, OFF_MEASSEL});
        end
      end
    end
    cmd_trg = cmd_trg | trg_event;
    ////////////////////////////////////////////////////////////////////
    // measurement sequencing
    fin = s_r.busy & MEAS_DONE_I;
    s_nxt.valid = s_nxt.valid | (fin & MEAS_OK_I);
    case (s_r.st)
      ST_IDLE: s_nxt.st = ST_IDLE;
      ST_SETTLE: begin
        if (dly_done) begin
          s_nxt.start = s_r.busy;
          s_nxt.st    = ST_MEAS;
        end
      end
      ST_MEAS: begin
        s_nxt.start = fin & ~MEAS_OK_I;
        if (!s_r.mode[MODE_SINGLE]) begin
          s_nxt.start = s_nxt.start | (fin & MEAS_OK_I);
          s_nxt.arm   = fin & MEAS_OK_I;
        end else begin
          s_nxt.busy = s_r.busy & ~(fin & MEAS_OK_I);
          if ((s_r.busy & ~(fin & MEAS_OK_I)) == '0) begin
            s_nxt.st = ST_IDLE;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (cmd_trg && |active && (s_r.st == ST_IDLE || s_r.st == ST_MEAS)) begin
      s_nxt.valid  = s_nxt.valid & ~active;
      s_nxt.busy   = active;
      s_nxt.arm    = active;
      s_nxt.start  = '0;
      s_nxt.dly_go = 1'b1;
      s_nxt.st     = ST_SETTLE;
    end
    if (|s_nxt.abort) begin
      s_nxt.start  = '0;
      s_nxt.arm    = '0;
      s_nxt.busy   = '0;
      s_nxt.dly_go = 1'b0;
      s_nxt.st     = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_r      <= '0;
      s_r.mode <= MODE_RST;
      s_r.st   <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O       = s_r.prdata;
  assign PREADY_O       = s_r.pready;
  assign PSLVERR_O      = s_r.pslverr;
  assign MEAS_START_O   = s_r.start;
  assign MEAS_ARM_O     = s_r.arm;
  assign MEAS_ABORT_O   = s_r.abort;
  assign STORE_SAVE_O   = s_r.save;
  assign STORE_RECALL_O = s_r.recall;
  assign STORE_SLOT_O   = s_r.slot;

  ////////////////////////////////////////////////////////////////////
  // assertions
  single_hold_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (s_r.st == ST_IDLE && s_r.mode[MODE_SINGLE] && !trg_event && !(acc_ph && PWRITE_I))
    |=> (s_r.st == ST_IDLE && MEAS_START_O == '0))
    else $error("start issued while holding in one-shot");
  slot_range_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (STORE_SAVE_O || STORE_RECALL_O) |-> (STORE_SLOT_O <= SLOT_MAX))
    else $error("store slot beyond range");
  abort_stop_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (|MEAS_ABORT_O) |-> (MEAS_START_O == '0 && s_r.busy == '0))
    else $error("abort left measurements running");
  result_gate_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (PREADY_O && s_r.rd_wait && !s_r.pslverr) |-> $past(s_r.valid[s_r.qsel]))
    else $error("result released while invalid");
  settle_run_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (s_r.dly_go && !s_r.mode[MODE_FAST]) |=> !dly_done [*8])
    else $error("full settling ended too early");
  fast_nodelay_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (s_r.dly_go && s_r.mode == 3'h1) |=> dly_done)
    else $error("fast settling added delay");
  cont_restart_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (s_r.st == ST_MEAS && !s_r.mode[MODE_SINGLE] && |(s_r.busy & MEAS_DONE_I & MEAS_OK_I)
     && !trg_event && !(acc_ph && PWRITE_I))
    |=> (MEAS_START_O == $past(s_r.busy & MEAS_DONE_I)))
    else $error("continuous mode did not restart");
  retry_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
    (s_r.st == ST_MEAS && |(s_r.busy & MEAS_DONE_I & ~MEAS_OK_I) && !trg_event
     && !(acc_ph && PWRITE_I)) |=> (|MEAS_START_O))
    else $error("failed cycle not retried");
endmodule
`default_nettype wire

// file: verification/mtc_meas_model.sv
// measurement engine model: answers each started cycle after a fixed latency
`timescale 1ns/100ps
`default_nettype none
module mtc_meas_model #(
  parameter int unsigned NM  = 8,
  parameter int unsigned LAT = 10
) (
  input  wire logic          clk_i,
  input  wire logic [NM-1:0] start_i,
  input  wire logic [NM-1:0] abort_i,
  input  wire logic          fail_i,
  output logic      [NM-1:0] done_o,
  output logic      [NM-1:0] ok_o,
  output logic      [31:0]   data_o,
  output logic      [31:0]   seq_o
);
  int unsigned cnt [NM];
  logic        fail_used;
  logic        fin;
  initial begin
    done_o = '0;
    ok_o = '0;
    data_o = 32'h0;
    seq_o = 32'h0;
    fail_used = 1'b0;
    foreach (cnt[i]) cnt[i] = 0;
  end
  always @(posedge clk_i) begin
    fin = 1'b0;
    done_o <= '0;
    ok_o <= '0;
    // data line carries nothing between results, so it keeps moving
    data_o <= ~data_o;
    for (int i = 0; i < NM; i++) begin
      if (start_i[i]) cnt[i] = LAT;
      else if (abort_i[i]) cnt[i] = 0;
      else if (cnt[i] == 1) begin
        cnt[i] = 0;
        fin = 1'b1;
        done_o[i] <= 1'b1;
        ok_o[i] <= !(fail_i && !fail_used);
      end else if (cnt[i] > 1) cnt[i] = cnt[i] - 1;
    end
    if (fin && fail_i) fail_used <= 1'b1;
    // one failed round on request, then valid results
    if (fin && !(fail_i && !fail_used)) begin
      seq_o <= seq_o + 1;
      data_o <= seq_o + 1;
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// testbench: trigger, rearm_policy, settling and save/recall checks over APB
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mtc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, get = 0, fail = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, mdata, seq, rd, r1;
  logic        pready, pslverr, serr, sav, rcl;
  logic [7:0]  screen = 8'h35, done, ok, start, arm, abrt, m_start;
  logic [6:0]  slot;
  int cyc = 0, t_last = 0, t_done = 0, n_start = 0, n_arm = 0, n_abort = 0;
  int n_save = 0, n_rcl = 0, err_total = 0, num_checks = 0, s, a, t0;
  logic [31:0] cw [6] = '{32'h20, 32'h6320, 32'h40, 32'h6340, 32'h6420, 32'h7F40};
  int          dly [4] = '{0, 2000, 2800, 800};
  logic [31:0] md [4] = '{32'h3, 32'h2, 32'h6, 32'h7};

  mtc_trigger_ctrl #(.NM(8)) i_dut (.MCLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .GET_I(get), .MEAS_SCREEN_I(screen),
    .MEAS_DONE_I(done), .MEAS_OK_I(ok), .MEAS_DATA_I(mdata), .MEAS_START_O(start),
    .MEAS_ARM_O(arm), .MEAS_ABORT_O(abrt), .STORE_SAVE_O(sav), .STORE_RECALL_O(rcl),
    .STORE_SLOT_O(slot));
  mtc_meas_model #(.NM(8), .LAT(10)) i_model (.clk_i(clk), .start_i(start), .abort_i(abrt),
    .fail_i(fail), .done_o(done), .ok_o(ok), .data_o(mdata), .seq_o(seq));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (|start) begin
      n_start <= n_start + 1;
      m_start <= start;
      t_last <= cyc;
    end
    if (|arm) n_arm <= n_arm + 1;
    if (|abrt) n_abort <= n_abort + 1;
    if (sav) n_save <= n_save + 1;
    if (rcl) n_rcl <= n_rcl + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20000);
    rd = prdata;
    serr = pslverr;
    t_done = cyc;
    psel <= 1'b0;
    pen <= 1'b0;
    chk("apb answer", 1, n < 20000);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mode;
    apb(0, OFF_MODE, 0);
    chk("mode after reset", {29'h0, MODE_RST}, {29'h0, rd[2:0]});
    foreach (md[i]) if (i < 2) begin
      apb(1, OFF_MODE, 32'h3);
      apb(1, OFF_CMD, 32'h1 << (i == 0 ? CMD_RESET : CMD_LOCAL));
      apb(0, OFF_MODE, 0);
      chk("mode default", {29'h0, MODE_RST}, {29'h0, rd[2:0]});
    end
    apb(1, OFF_CMD, 32'h1 << CMD_REMOTE);
    apb(0, OFF_MODE, 0);
    chk("mode on remote", 32'h3, {29'h0, rd[2:0]});
    $display("test mode done");
  endtask
  task automatic t_settle;
    apb(1, OFF_ENABLE, 32'h0F);
    apb(1, OFF_MEASSEL, 0);
    foreach (md[i]) begin
      apb(1, OFF_MODE, md[i]);
      s = n_start;
      apb(1, OFF_CMD, 32'h1 << CMD_TRG);
      t0 = t_done;
      wt(dly[i] + 40);
      chk("start count", 1, n_start - s);
      chk("start mask", 32'h05, {24'h0, m_start});
      chk("delay", 1, t_last - t0 >= dly[i] && t_last - t0 <= dly[i] + 6);
      apb(0, OFF_STATUS, 0);
      chk("valid flags", 32'h05, rd);
      apb(0, OFF_RESULT, 0);
      r1 = rd;
      apb(0, OFF_RESULT, 0);
      chk("held result", r1, rd);
      chk("result value", seq, rd);
    end
    $display("test settle done");
  endtask
  task automatic t_get;
    apb(1, OFF_MODE, 32'h3);
    s = n_start;
    fail <= 1'b1;
    get <= 1'b1;
    wt(80);
    fail <= 1'b0;
    get <= 1'b0;
    chk("retry starts", 2, n_start - s);
    chk("get mask", 32'h05, {24'h0, m_start});
    apb(1, OFF_MODE, 32'h2);
    r1 = seq + 1;
    s = n_start;
    apb(1, OFF_CMD, 32'h1);
    for (int n = 0; n < 3000 && n_start == s; n++) @(posedge clk);
    apb(0, OFF_RESULT, 0);
    chk("stalled result", r1, rd);
    $display("test get and stall done");
  endtask
  task automatic t_cont;
    apb(1, OFF_MODE, 32'h1);
    s = n_start;
    a = n_arm;
    apb(1, OFF_CMD, 32'h1);
    wt(100);
    chk("restarts", 1, n_start - s >= 4);
    chk("rearms", 1, n_arm - a >= 3);
    apb(0, OFF_RESULT, 0);
    r1 = rd;
    wt(30);
    apb(0, OFF_RESULT, 0);
    chk("fresh result", 1, rd !== r1);
    a = n_abort;
    apb(1, OFF_CMD, 32'h1 << CMD_ABORT);
    wt(5);
    s = n_start;
    wt(100);
    chk("abort pulse", 1, n_abort > a);
    chk("no start after abort", 0, n_start - s);
    apb(0, OFF_STATUS, 0);
    chk("busy after abort", 0, {16'h0, rd[31:16]});
    $display("test continuous done");
  endtask
  task automatic t_store;
    foreach (cw[i]) begin
      s = n_save;
      a = n_rcl;
      apb(1, OFF_CMD, cw[i]);
      chk("store refusal", i >= 4, serr);
      wt(3);
      chk("save pulse", i < 4 && cw[i][5], n_save - s);
      chk("recall pulse", i < 4 && cw[i][6], n_rcl - a);
      chk("slot", i >= 4 ? 32'h63 : {25'h0, cw[i][14:8]}, {25'h0, slot});
      apb(0, OFF_STORE, 0);
      chk("store error bit", i >= 4, rd[7]);
    end
    apb(0, 12'h020, 0);
    chk("unmapped", 1, serr);
    apb(1, OFF_SCREEN, 0);
    chk("read only", 1, serr);
    apb(0, OFF_ENABLE, 0);
    chk("enable readback", 32'h0F, rd);
    $display("test store done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    wt(2);
    rst_n <= 1'b1;
    wt(4);
    t_mode();
    t_settle();
    t_get();
    t_cont();
    t_store();
    finish_test();
  end
  initial begin
    wt(40000);
    err_total++;
    $display("CHECK FAILED watchdog expected end seen timeout");
    finish_test();
  end
endmodule
`default_nettype wire
